/* File: common/audio_clock_params.svh */
`ifndef AUDIO_CLOCK_PARAMS_SVH
`define AUDIO_CLOCK_PARAMS_SVH

// System clock rate in Hz
`define ACS_CLK_HZ         100000000

// Nominal sample rates in Hz
`define ACS_HZ_32K         32000
`define ACS_HZ_44K1        44100
`define ACS_HZ_48K         48000
`define ACS_HZ_88K2        88200
`define ACS_HZ_96K         96000
`define ACS_HZ_176K4       176400
`define ACS_HZ_192K        192000

// Accepted period deviation in percent
`define ACS_TOL_PCT        2

// Slowest rate, used to derive the no-edge timeout
`define ACS_HZ_SLOWEST     32000

// Matching periods needed before an input counts as stable
`define ACS_STABLE_CNT     3

// Usable channels per optical port at each speed
`define ACS_CH_SINGLE      8
`define ACS_CH_DOUBLE      4
`define ACS_CH_QUAD        2

// Reset values
`define ACS_RST_SRC        2'h0
`define ACS_RST_RATE       3'h0

`endif

/* File: common/audio_clock_pkg.sv */
package audio_clock_pkg;
`include "audio_clock_params.svh"

    typedef enum logic [1:0] {SRC_INT, SRC_WC, SRC_ADAT, SRC_AES} src_e;

    typedef enum logic [2:0] {
        RATE_NONE, RATE_32K, RATE_44K1, RATE_48K,
        RATE_88K2, RATE_96K, RATE_176K4, RATE_192K
    } rate_e;

    typedef enum logic [1:0] {IN_NO_LOCK, IN_LOCK, IN_SYNC} lock_e;

    typedef enum logic [1:0] {SPD_SINGLE, SPD_DOUBLE, SPD_QUAD} speed_e;

    function automatic int rate_hz(input rate_e r);
        case (r)
            RATE_32K:   rate_hz = `ACS_HZ_32K;
            RATE_44K1:  rate_hz = `ACS_HZ_44K1;
            RATE_48K:   rate_hz = `ACS_HZ_48K;
            RATE_88K2:  rate_hz = `ACS_HZ_88K2;
            RATE_96K:   rate_hz = `ACS_HZ_96K;
            RATE_176K4: rate_hz = `ACS_HZ_176K4;
            RATE_192K:  rate_hz = `ACS_HZ_192K;
            default:    rate_hz = 0;
        endcase
    endfunction : rate_hz

    // Period in system clocks to rate code; none if no window matches
    function automatic rate_e classify(input logic [15:0] period);
        int    nom;
        int    dev;
        rate_e r;
        classify = RATE_NONE;
        for (int i = 1; i < 8; i++) begin
            r   = rate_e'(i[2:0]);
            nom = `ACS_CLK_HZ / rate_hz(r);
            dev = int'(period) - nom;
            if (dev < 0) begin
                dev = -dev;
            end
            if (dev * 100 <= nom * `ACS_TOL_PCT) begin
                classify = r;
            end
        end
    endfunction : classify

    function automatic speed_e speed_of(input rate_e r);
        case (r)
            RATE_88K2, RATE_96K:   speed_of = SPD_DOUBLE;
            RATE_176K4, RATE_192K: speed_of = SPD_QUAD;
            default:               speed_of = SPD_SINGLE;
        endcase
    endfunction : speed_of

endpackage : audio_clock_pkg

/* File: hdl/rate_meter.sv */
`timescale 1ns/1ns
`include "audio_clock_params.svh"
// Measures the spacing of edge ticks and classifies it as a sample rate
module rate_meter #(
    parameter int CNT_W       = 16,
    parameter int TIMEOUT_CYC = 6250
) (
    input  wire logic                 clk,
    input  wire logic                 rstn,
    input  wire logic                 ce,
    input  wire logic                 tick,
    output audio_clock_pkg::rate_e    rate,
    output logic                      stable
);
    localparam logic [CNT_W-1:0] TIMEOUT = CNT_W'(TIMEOUT_CYC);
    localparam logic [1:0]       STABLE_N = 2'(`ACS_STABLE_CNT);

    logic [CNT_W-1:0]       cnt_r;
    logic [CNT_W-1:0]       cnt_nxt;
    logic [1:0]             hits_r;
    logic [1:0]             hits_nxt;
    audio_clock_pkg::rate_e rate_r;
    audio_clock_pkg::rate_e rate_nxt;
    audio_clock_pkg::rate_e meas;

    always_comb begin
        cnt_nxt  = cnt_r;
        hits_nxt = hits_r;
        rate_nxt = rate_r;
        meas     = audio_clock_pkg::classify(cnt_r);
        if (tick) begin
            cnt_nxt = '0;
            // A rate is only trusted after several equal periods in a row
            if (meas != audio_clock_pkg::RATE_NONE && meas == rate_r) begin
                hits_nxt = (hits_r == STABLE_N) ? hits_r : hits_r + 2'h1;
            end else begin
                hits_nxt = '0;
            end
            rate_nxt = meas;
        end else if (cnt_r >= TIMEOUT) begin
            // Input has gone quiet: drop to no lock
            rate_nxt = audio_clock_pkg::RATE_NONE;
            hits_nxt = '0;
        end else begin
            cnt_nxt = cnt_r + CNT_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r  <= '0;
            hits_r <= 2'h0;
            rate_r <= audio_clock_pkg::rate_e'(`ACS_RST_RATE);
        end else if (ce) begin
            cnt_r  <= cnt_nxt;
            hits_r <= hits_nxt;
            rate_r <= rate_nxt;
        end
    end

    assign rate   = rate_r;
    assign stable = (hits_r == STABLE_N) && (rate_r != audio_clock_pkg::RATE_NONE);

endmodule : rate_meter

/* File: hdl/audio_clock_source_selector.sv */
`timescale 1ns/1ns
`include "audio_clock_params.svh"
module audio_clock_source_selector #(
    parameter int TIMEOUT_CYC = 2 * (`ACS_CLK_HZ / `ACS_HZ_SLOWEST),
    parameter int CNT_W       = 16
) (
    input  wire logic                    clk,
    input  wire logic                    rstn,
    input  wire logic                    ce,
    input  wire logic                    link_clk,
    input  wire logic                    wc_pin,
    input  wire logic                    adat_pin,
    input  wire logic                    aes_pin,
    input  wire logic                    adat_rx_lock,
    input  wire logic                    aes_rx_lock,
    input  wire logic                    master_mode,
    input  audio_clock_pkg::src_e        pref_src,
    input  audio_clock_pkg::rate_e       host_rate,
    output audio_clock_pkg::src_e        cur_src,
    output audio_clock_pkg::rate_e       cur_rate,
    output audio_clock_pkg::rate_e       wc_rate,
    output audio_clock_pkg::rate_e       adat_rate,
    output audio_clock_pkg::rate_e       aes_rate,
    output audio_clock_pkg::lock_e       wc_state,
    output audio_clock_pkg::lock_e       adat_state,
    output audio_clock_pkg::lock_e       aes_state,
    output logic                         rate_mismatch,
    output audio_clock_pkg::speed_e      speed,
    output logic [3:0]                   adat_chans,
    output audio_clock_pkg::src_e        link_src
);
    localparam int N_IN = 3;
    localparam int IX_WC = 0;
    localparam int IX_ADAT = 1;
    localparam int IX_AES = 2;

    // Pin and receiver-lock synchronisers
    // A third pin stage feeds only the edge compare, never the settling pair

    logic [N_IN-1:0] pin_s1_r;
    logic [N_IN-1:0] pin_s2_r;
    logic [N_IN-1:0] pin_s3_r;
    logic [N_IN-1:0] pin_s1_nxt;
    logic [N_IN-1:0] pin_s2_nxt;
    logic [N_IN-1:0] pin_s3_nxt;
    logic [1:0]      lk_s1_r;
    logic [1:0]      lk_s2_r;
    logic [1:0]      lk_s1_nxt;
    logic [1:0]      lk_s2_nxt;
    logic [N_IN-1:0] tick;

    always_comb begin
        pin_s1_nxt = {aes_pin, adat_pin, wc_pin};
        pin_s2_nxt = pin_s1_r;
        pin_s3_nxt = pin_s2_r;
        lk_s1_nxt  = {aes_rx_lock, adat_rx_lock};
        lk_s2_nxt  = lk_s1_r;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            pin_s3_r <= '0;
            lk_s1_r  <= 2'h0;
            lk_s2_r  <= 2'h0;
        end else if (ce) begin
            pin_s1_r <= pin_s1_nxt;
            pin_s2_r <= pin_s2_nxt;
            pin_s3_r <= pin_s3_nxt;
            lk_s1_r  <= lk_s1_nxt;
            lk_s2_r  <= lk_s2_nxt;
        end
    end

    // Rising edge of each frame pin, taken after the second stage only
    assign tick = pin_s2_r & ~pin_s3_r;

    // Rate meters; optical and AES run side by side at all times
    audio_clock_pkg::rate_e meas_rate [N_IN];
    logic [N_IN-1:0]        meas_stable;
    logic [N_IN-1:0]        in_valid;

    for (genvar g = 0; g < N_IN; g++) begin : g_meter
        rate_meter #(
            .CNT_W       (CNT_W),
            .TIMEOUT_CYC (TIMEOUT_CYC)
        ) u_meter (
            .clk    (clk),
            .rstn   (rstn),
            .ce     (ce),
            .tick   (tick[g]),
            .rate   (meas_rate[g]),
            .stable (meas_stable[g])
        );
    end

    // Optical and AES also need their receivers to report lock
    assign in_valid[IX_WC]   = meas_stable[IX_WC];
    assign in_valid[IX_ADAT] = meas_stable[IX_ADAT] & lk_s2_r[0];
    assign in_valid[IX_AES]  = meas_stable[IX_AES] & lk_s2_r[1];

    function automatic logic src_valid(input audio_clock_pkg::src_e s, input logic [N_IN-1:0] v);
        case (s)
            audio_clock_pkg::SRC_WC:   src_valid = v[IX_WC];
            audio_clock_pkg::SRC_ADAT: src_valid = v[IX_ADAT];
            audio_clock_pkg::SRC_AES:  src_valid = v[IX_AES];
            default:                   src_valid = 1'b0;
        endcase
    endfunction : src_valid

    function automatic audio_clock_pkg::lock_e in_state(input logic valid, input audio_clock_pkg::rate_e r,
                                                       input audio_clock_pkg::rate_e cur);
        if (!valid) begin
            in_state = audio_clock_pkg::IN_NO_LOCK;
        end else if (r != cur) begin
            in_state = audio_clock_pkg::IN_LOCK;
        end else begin
            in_state = audio_clock_pkg::IN_SYNC;
        end
    endfunction : in_state

    // Source choice and status

    audio_clock_pkg::src_e   src_r;
    audio_clock_pkg::src_e   src_nxt;
    audio_clock_pkg::rate_e  cur_rate_r;
    audio_clock_pkg::rate_e  cur_rate_nxt;
    audio_clock_pkg::rate_e  in_rate_r [N_IN];
    audio_clock_pkg::rate_e  in_rate_nxt [N_IN];
    audio_clock_pkg::lock_e  in_state_r [N_IN];
    audio_clock_pkg::lock_e  in_state_nxt [N_IN];
    logic                    mism_r;
    logic                    mism_nxt;
    audio_clock_pkg::speed_e speed_r;
    audio_clock_pkg::speed_e speed_nxt;
    logic [3:0]              chans_r;
    logic [3:0]              chans_nxt;

    always_comb begin
        if (master_mode) begin
            src_nxt = audio_clock_pkg::SRC_INT;
        end else if (src_valid(pref_src, in_valid)) begin
            src_nxt = pref_src;
        end else if (in_valid[IX_WC]) begin
            src_nxt = audio_clock_pkg::SRC_WC;
        end else if (in_valid[IX_ADAT]) begin
            src_nxt = audio_clock_pkg::SRC_ADAT;
        end else if (in_valid[IX_AES]) begin
            src_nxt = audio_clock_pkg::SRC_AES;
        end else begin
            src_nxt = audio_clock_pkg::SRC_INT;
        end

        case (src_nxt)
            audio_clock_pkg::SRC_WC:   cur_rate_nxt = meas_rate[IX_WC];
            audio_clock_pkg::SRC_ADAT: cur_rate_nxt = meas_rate[IX_ADAT];
            audio_clock_pkg::SRC_AES:  cur_rate_nxt = meas_rate[IX_AES];
            default:                   cur_rate_nxt = host_rate;
        endcase

        // Phase is not compared: a rate match with lock counts as synchronous
        for (int i = 0; i < N_IN; i++) begin
            in_rate_nxt[i]  = in_valid[i] ? meas_rate[i] : audio_clock_pkg::RATE_NONE;
            in_state_nxt[i] = in_state(in_valid[i], meas_rate[i], cur_rate_nxt);
        end

        // The internal clock always runs at the host rate, so it never mismatches
        mism_nxt = (src_nxt != audio_clock_pkg::SRC_INT) && (cur_rate_nxt != host_rate);

        speed_nxt = audio_clock_pkg::speed_of(cur_rate_nxt);
        case (speed_nxt)
            audio_clock_pkg::SPD_DOUBLE: chans_nxt = 4'(`ACS_CH_DOUBLE);
            audio_clock_pkg::SPD_QUAD:   chans_nxt = 4'(`ACS_CH_QUAD);
            default:                     chans_nxt = 4'(`ACS_CH_SINGLE);
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            src_r      <= audio_clock_pkg::src_e'(`ACS_RST_SRC);
            cur_rate_r <= audio_clock_pkg::rate_e'(`ACS_RST_RATE);
            for (int i = 0; i < N_IN; i++) begin
                in_rate_r[i]  <= audio_clock_pkg::rate_e'(`ACS_RST_RATE);
                in_state_r[i] <= audio_clock_pkg::IN_NO_LOCK;
            end
            mism_r  <= 1'b0;
            speed_r <= audio_clock_pkg::SPD_SINGLE;
            chans_r <= 4'(`ACS_CH_SINGLE);
        end else if (ce) begin
            src_r      <= src_nxt;
            cur_rate_r <= cur_rate_nxt;
            for (int i = 0; i < N_IN; i++) begin
                in_rate_r[i]  <= in_rate_nxt[i];
                in_state_r[i] <= in_state_nxt[i];
            end
            mism_r  <= mism_nxt;
            speed_r <= speed_nxt;
            chans_r <= chans_nxt;
        end
    end

    assign cur_src       = src_r;
    assign cur_rate      = cur_rate_r;
    assign wc_rate       = in_rate_r[IX_WC];
    assign adat_rate     = in_rate_r[IX_ADAT];
    assign aes_rate      = in_rate_r[IX_AES];
    assign wc_state      = in_state_r[IX_WC];
    assign adat_state    = in_state_r[IX_ADAT];
    assign aes_state     = in_state_r[IX_AES];
    assign rate_mismatch = mism_r;
    assign speed         = speed_r;
    assign adat_chans    = chans_r;

    // Source hand-off to the link domain by toggle handshake.
    // The held word does not move while a request is open, so the
    // link side may sample it without a gray code.

    audio_clock_pkg::src_e hold_r;
    audio_clock_pkg::src_e hold_nxt;
    logic                  req_r;
    logic                  req_nxt;
    logic                  ack_s1_r;
    logic                  ack_s2_r;
    logic                  ack_lk_r;
    logic                  busy;

    assign busy = req_r ^ ack_s2_r;

    always_comb begin
        hold_nxt = hold_r;
        req_nxt  = req_r;
        if (!busy && hold_r != src_r) begin
            hold_nxt = src_r;
            req_nxt  = ~req_r;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hold_r   <= audio_clock_pkg::src_e'(`ACS_RST_SRC);
            req_r    <= 1'b0;
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
        end else if (ce) begin
            hold_r   <= hold_nxt;
            req_r    <= req_nxt;
            ack_s1_r <= ack_lk_r;
            ack_s2_r <= ack_s1_r;
        end
    end

    // Link clock domain
    // Not gated by ce: this side only copies the held word, which ce already freezes

    logic                  req_s1_r;
    logic                  req_s2_r;
    logic                  ack_lk_nxt;
    audio_clock_pkg::src_e lsrc_r;
    audio_clock_pkg::src_e lsrc_nxt;

    always_comb begin
        ack_lk_nxt = ack_lk_r;
        lsrc_nxt   = lsrc_r;
        if (req_s2_r != ack_lk_r) begin
            lsrc_nxt   = hold_r;
            ack_lk_nxt = req_s2_r;
        end
    end

    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
            ack_lk_r <= 1'b0;
            lsrc_r   <= audio_clock_pkg::src_e'(`ACS_RST_SRC);
        end else begin
            req_s1_r <= req_r;
            req_s2_r <= req_s1_r;
            ack_lk_r <= ack_lk_nxt;
            lsrc_r   <= lsrc_nxt;
        end
    end

    assign link_src = lsrc_r;

endmodule : audio_clock_source_selector

/* File: tb/audio_source_model.sv */
`timescale 1ns/1ns
module audio_source_model (
    input  int   wc_half,
    input  int   adat_half,
    input  int   aes_half,
    input  logic adat_lock_en,
    input  logic aes_lock_en,
    output logic wc_pin,
    output logic adat_pin,
    output logic aes_pin,
    output logic adat_rx_lock,
    output logic aes_rx_lock
);
    // A silent source parks its line low: no clock runs outside a live stream
    always begin
        if (wc_half > 0) begin
            #(wc_half) wc_pin = (wc_pin !== 1'b1);
        end else begin
            wc_pin = 1'b0;
            #50;
        end
    end

    always begin
        if (adat_half > 0) begin
            #(adat_half) adat_pin = (adat_pin !== 1'b1);
        end else begin
            adat_pin = 1'b0;
            #50;
        end
    end

    always begin
        if (aes_half > 0) begin
            #(aes_half) aes_pin = (aes_pin !== 1'b1);
        end else begin
            aes_pin = 1'b0;
            #50;
        end
    end

    // Receiver lock is separate so a running line can still be unlocked
    assign adat_rx_lock = adat_lock_en;
    assign aes_rx_lock  = aes_lock_en;
endmodule : audio_source_model

/* File: tb/audio_clock_source_selector_monitor.sv */
`timescale 1ns/1ns
module audio_clock_source_selector_monitor (
    input logic                    clk,
    input logic                    rstn,
    input logic                    ce,
    input logic                    master_mode,
    input audio_clock_pkg::src_e   pref_src,
    input audio_clock_pkg::rate_e  host_rate,
    input audio_clock_pkg::src_e   cur_src,
    input audio_clock_pkg::rate_e  cur_rate,
    input audio_clock_pkg::rate_e  wc_rate,
    input audio_clock_pkg::lock_e  wc_state,
    input audio_clock_pkg::rate_e  adat_rate,
    input audio_clock_pkg::lock_e  adat_state,
    input logic                    rate_mismatch,
    input audio_clock_pkg::speed_e speed,
    input logic [3:0]              adat_chans,
    input audio_clock_pkg::src_e   link_src
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    AST_MASTER_SRC: assert property (ce && master_mode |=> cur_src == audio_clock_pkg::SRC_INT)
        else $error("master mode left the internal clock");
    AST_MASTER_RATE: assert property (ce && master_mode |=> cur_rate == $past(host_rate))
        else $error("master mode rate differs from host rate");
    AST_PREF_WINS: assert property ((ce && !master_mode && pref_src == audio_clock_pkg::SRC_WC
        && wc_state != audio_clock_pkg::IN_NO_LOCK)[*2] |-> cur_src == audio_clock_pkg::SRC_WC)
        else $error("valid preferred input not selected");
    AST_SYNC_RATE: assert property (adat_state == audio_clock_pkg::IN_SYNC |->
        adat_rate == cur_rate && adat_rate != audio_clock_pkg::RATE_NONE)
        else $error("sync reported at a foreign rate");
    AST_NOLOCK_NONE: assert property ((wc_rate == audio_clock_pkg::RATE_NONE)
        == (wc_state == audio_clock_pkg::IN_NO_LOCK))
        else $error("no-lock and unknown rate disagree");
    AST_SPEED_CLASS: assert property ($stable(cur_rate) |-> speed ==
        (cur_rate inside {audio_clock_pkg::RATE_88K2, audio_clock_pkg::RATE_96K} ? audio_clock_pkg::SPD_DOUBLE :
        cur_rate inside {audio_clock_pkg::RATE_176K4, audio_clock_pkg::RATE_192K} ? audio_clock_pkg::SPD_QUAD :
        audio_clock_pkg::SPD_SINGLE))
        else $error("speed class wrong");
    AST_CHANS: assert property ($stable(speed) |-> adat_chans ==
        (speed == audio_clock_pkg::SPD_QUAD ? 4'h2 : speed == audio_clock_pkg::SPD_DOUBLE ? 4'h4 : 4'h8))
        else $error("channel count wrong");
    AST_MISMATCH_INT: assert property ((cur_src == audio_clock_pkg::SRC_INT)[*2] |-> !rate_mismatch)
        else $error("mismatch flagged on internal clock");
    AST_MISMATCH_SET: assert property ((cur_src != audio_clock_pkg::SRC_INT && cur_rate != host_rate
        && $stable(host_rate))[*2] |-> rate_mismatch)
        else $error("mismatch not flagged");
    AST_LINK_FOLLOW: assert property (cur_src != link_src |-> ##[1:80] cur_src == link_src)
        else $error("link side never caught up");

    cover property (cur_src == audio_clock_pkg::SRC_ADAT);
    cover property (cur_src == audio_clock_pkg::SRC_AES && rate_mismatch);
    cover property (speed == audio_clock_pkg::SPD_QUAD);
endmodule : audio_clock_source_selector_monitor

/* File: tb/audio_clock_source_selector_tb_top.sv */
`timescale 1ns/1ns
module audio_clock_source_selector_tb_top;
    logic                    clk, rstn, ce, link_clk, master_mode, rate_mismatch;
    logic                    wc_pin, adat_pin, aes_pin, adat_rx_lock, aes_rx_lock, adat_lock_en, aes_lock_en;
    logic [3:0]              adat_chans;
    audio_clock_pkg::src_e   pref_src, cur_src, link_src;
    audio_clock_pkg::rate_e  host_rate, cur_rate, wc_rate, adat_rate, aes_rate;
    audio_clock_pkg::lock_e  wc_state, adat_state, aes_state;
    audio_clock_pkg::speed_e speed;
    int                      wc_half, adat_half, aes_half, error_cnt, total_checks;

    // Shorter loss timeout keeps the run brief; still above 1.2x the slowest period used
    audio_clock_source_selector #(.TIMEOUT_CYC(3000), .CNT_W(16)) dut_u (.clk(clk), .rstn(rstn), .ce(ce),
        .link_clk(link_clk), .wc_pin(wc_pin), .adat_pin(adat_pin), .aes_pin(aes_pin),
        .adat_rx_lock(adat_rx_lock), .aes_rx_lock(aes_rx_lock), .master_mode(master_mode),
        .pref_src(pref_src), .host_rate(host_rate), .cur_src(cur_src), .cur_rate(cur_rate),
        .wc_rate(wc_rate), .adat_rate(adat_rate), .aes_rate(aes_rate), .wc_state(wc_state),
        .adat_state(adat_state), .aes_state(aes_state), .rate_mismatch(rate_mismatch),
        .speed(speed), .adat_chans(adat_chans), .link_src(link_src));

    audio_source_model src_u (.wc_half(wc_half), .adat_half(adat_half), .aes_half(aes_half),
        .adat_lock_en(adat_lock_en), .aes_lock_en(aes_lock_en), .wc_pin(wc_pin), .adat_pin(adat_pin),
        .aes_pin(aes_pin), .adat_rx_lock(adat_rx_lock), .aes_rx_lock(aes_rx_lock));

    always #5 clk = ~clk;

    initial begin
        link_clk = 1'b0;
        #7;
        forever #15 link_clk = ~link_clk;
    end

    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: value %0h, expected %0h", $time, got, exp);
        end
    endtask : chk

    task automatic wait_src(input audio_clock_pkg::src_e exp);
        int n;
        n = 0;
        while (cur_src !== exp && n < 20000) begin
            @(negedge clk);
            n++;
        end
        repeat (3) @(negedge clk);
        chk(cur_src, exp);
    endtask : wait_src

    task automatic t_master();
        int n;
        @(posedge clk);
        wc_half <= 5208;
        n = 0;
        while (wc_state === audio_clock_pkg::IN_NO_LOCK && n < 20000) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        chk(cur_src, audio_clock_pkg::SRC_INT);
        chk(cur_rate, audio_clock_pkg::RATE_48K);
        chk(wc_rate, audio_clock_pkg::RATE_96K);
        chk(wc_state, audio_clock_pkg::IN_LOCK);
        chk(rate_mismatch, 1'b0);
    endtask : t_master

    task automatic t_follow();
        int n;
        @(posedge clk);
        ce          <= 1'b0;
        master_mode <= 1'b0;
        repeat (5) @(negedge clk);
        chk(cur_src, audio_clock_pkg::SRC_INT);
        @(posedge clk);
        ce <= 1'b1;
        wait_src(audio_clock_pkg::SRC_WC);
        chk(cur_rate, audio_clock_pkg::RATE_96K);
        chk(wc_state, audio_clock_pkg::IN_SYNC);
        chk(speed, audio_clock_pkg::SPD_DOUBLE);
        chk(adat_chans, 4'h4);
        chk(rate_mismatch, 1'b1);
        n = 0;
        while (link_src !== audio_clock_pkg::SRC_WC && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk(link_src, audio_clock_pkg::SRC_WC);
    endtask : t_follow

    task automatic t_pref();
        @(posedge clk);
        adat_half    <= 2604;
        adat_lock_en <= 1'b1;
        pref_src     <= audio_clock_pkg::SRC_ADAT;
        wait_src(audio_clock_pkg::SRC_ADAT);
        chk(speed, audio_clock_pkg::SPD_QUAD);
        chk(adat_chans, 4'h2);
        chk(wc_state, audio_clock_pkg::IN_LOCK);
        chk(adat_state, audio_clock_pkg::IN_SYNC);
        @(posedge clk);
        adat_lock_en <= 1'b0;
        wait_src(audio_clock_pkg::SRC_WC);
    endtask : t_pref

    task automatic t_prio();
        @(posedge clk);
        pref_src     <= audio_clock_pkg::SRC_AES;
        adat_lock_en <= 1'b1;
        repeat (20) @(negedge clk);
        chk(cur_src, audio_clock_pkg::SRC_WC);
        @(posedge clk);
        wc_half <= 0;
        wait_src(audio_clock_pkg::SRC_ADAT);
        @(posedge clk);
        adat_lock_en <= 1'b0;
        aes_half     <= 11338;
        aes_lock_en  <= 1'b1;
        wait_src(audio_clock_pkg::SRC_AES);
        chk(cur_rate, audio_clock_pkg::RATE_44K1);
        chk(aes_state, audio_clock_pkg::IN_SYNC);
        chk(adat_rate, audio_clock_pkg::RATE_NONE);
        chk(rate_mismatch, 1'b1);
        chk(speed, audio_clock_pkg::SPD_SINGLE);
        chk(adat_chans, 4'h8);
        @(posedge clk);
        host_rate <= audio_clock_pkg::RATE_44K1;
        repeat (3) @(negedge clk);
        chk(rate_mismatch, 1'b0);
    endtask : t_prio

    task automatic t_loss();
        @(posedge clk);
        aes_half    <= 0;
        aes_lock_en <= 1'b0;
        wait_src(audio_clock_pkg::SRC_INT);
        chk(cur_rate, audio_clock_pkg::RATE_44K1);
        chk(aes_rate, audio_clock_pkg::RATE_NONE);
        chk(aes_state, audio_clock_pkg::IN_NO_LOCK);
        repeat (100) @(negedge clk);
        chk(link_src, audio_clock_pkg::SRC_INT);
    endtask : t_loss

    task automatic end_of_test();
        $display("Checks %0d, errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test

    initial begin
        #500_000;
        error_cnt++;
        $display("ERROR at %0t: watchdog expired", $time);
        end_of_test();
    end

    initial begin
        clk = 1'b0; rstn = 1'b0; ce = 1'b1; master_mode = 1'b1;
        pref_src = audio_clock_pkg::SRC_WC; host_rate = audio_clock_pkg::RATE_48K;
        wc_half = 0; adat_half = 0; aes_half = 0; adat_lock_en = 1'b0; aes_lock_en = 1'b0;
        error_cnt = 0; total_checks = 0;
        repeat (3) @(posedge clk);
        chk(cur_src, audio_clock_pkg::SRC_INT);
        chk(wc_state, audio_clock_pkg::IN_NO_LOCK);
        chk(adat_chans, 4'h8);
        rstn <= 1'b1;
        t_master();
        t_follow();
        t_pref();
        t_prio();
        t_loss();
        end_of_test();
    end
endmodule : audio_clock_source_selector_tb_top

bind audio_clock_source_selector audio_clock_source_selector_monitor mon_u (.clk(clk), .rstn(rstn), .ce(ce),
    .master_mode(master_mode), .pref_src(pref_src), .host_rate(host_rate), .cur_src(cur_src),
    .cur_rate(cur_rate), .wc_rate(wc_rate), .wc_state(wc_state), .adat_rate(adat_rate),
    .adat_state(adat_state), .rate_mismatch(rate_mismatch), .speed(speed), .adat_chans(adat_chans),
    .link_src(link_src));
